// ---- rtl/llc_pkg.sv ----
package llc_pkg;
  localparam int CLK_HZ       = 50_000_000;
  localparam int CLK_NS       = 20;
  localparam int BLANK_NS     = 400;
  localparam int BLANK_CYC    = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_MAX_NS  = 1000;
  localparam int DEAD_MAX_CYC = DEAD_MAX_NS / CLK_NS;
  localparam int AVG_HI_MS    = 2;
  localparam int AVG_LO_MS    = 50;
  localparam int RESTART_MS   = 200;
  localparam int AVG_HI_CYC   = AVG_HI_MS * (CLK_HZ / 1000);
  localparam int AVG_LO_CYC   = AVG_LO_MS * (CLK_HZ / 1000);
  localparam int RESTART_CYC  = RESTART_MS * (CLK_HZ / 1000);
  localparam int PEAK_EVENTS  = 4;
  localparam int PEAK_IGNORE  = 15;
  localparam int BURST_CYCLES = 4;
  localparam int CNT_W        = 24;
  localparam int DEAD_W       = 8;

  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] STAT_OFF   = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_SOFT_START_ENABLED_BIT = 1;
  localparam int ST_PEAK       = 0;
  localparam int ST_AVG_HI     = 1;
  localparam int ST_AVG_LO     = 2;
  localparam int ST_BULK_OV    = 3;
  localparam int ST_OUT_OV     = 4;
  localparam int ST_RESTART    = 5;
  localparam int ST_CAP        = 8;
  localparam int ST_SSDONE     = 9;
  localparam int ST_BULKOK     = 10;
  localparam int ST_STATE_LSB  = 16;

  typedef struct packed {
    logic tank_above_upper;
    logic tank_below_lower;
    logic tank_above_cm;
    logic current_polarity;
    logic slew_done;
    logic peak_overcurrent;
    logic avg_overcurrent_high;
    logic avg_overcurrent_low;
    logic bulk_overvoltage;
    logic bulk_above_start;
    logic bulk_above_stop;
    logic output_ov;
    logic feedback_below_burst_level;
    logic feedback_below_softstart;
    logic boot_supply_uv;
    logic regulated_supply_uv;
  } cmp_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_HIGH    = 5'h02,
    ST_DEAD_HL = 5'h04,
    ST_LOW     = 5'h08,
    ST_DEAD_LH = 5'h10
  } wave_state_t;
endpackage

// ---- rtl/llc_waveform_protection_logic.sv ----
`timescale 1ns/1ps
module llc_waveform_protection_logic #(
  parameter int AVG_HI_CYCLES  = llc_pkg::AVG_HI_CYC,
  parameter int AVG_LO_CYCLES  = llc_pkg::AVG_LO_CYC,
  parameter int RESTART_CYCLES = llc_pkg::RESTART_CYC
) (
  input  wire logic          CLK_SYS,          // System clock, 50 MHz
  input  wire logic          RESET,            // Async reset, active high
  input  wire logic          PSEL,             // APB select
  input  wire logic          PENABLE,          // APB access phase
  input  wire logic          PWRITE,           // APB write
  input  wire logic [11:0]   PADDR,            // APB byte address
  input  wire logic [31:0]   PWDATA,           // APB write data
  output logic      [31:0]   PRDATA,           // APB read data
  output logic               PREADY,           // APB ready
  output logic               PSLVERR,          // APB error, unmapped
  input  wire llc_pkg::cmp_t CMP,              // Analog comparator results
  output logic               HIGH_GATE_OUT,    // High-side gate command
  output logic               LOW_GATE_OUT,     // Low-side gate command
  output logic               DRIVER_LOW_POWER, // Gate drivers in low power
  output logic               TANK_CLAMP,       // Short tank node to mid-level
  output logic               RAMP_ENABLE,      // Compensation ramp on
  output logic               RAMP_SOURCE,      // 1 sources, 0 sinks ramp
  output logic               AVG_PATH_SEL,     // Pass differentiator to filter
  output logic               BURST_SEL_GND,    // Burst selector takes ground
  output logic               BULK_OV_SEL_RISE, // Bulk comparator uses rise level
  output logic               WINDING_SAMPLE,   // Winding sample/hold strobe
  output logic               SS_PULLDOWN,      // Soft-start pin pull-down
  output logic               SOFTSTART_DONE,   // Soft start finished
  output logic               FAULT,            // Any latched fault
  output logic               RESTART_REQ       // Restart request to system
);

  llc_pkg::cmp_t          sync1;
  llc_pkg::cmp_t          c;
  llc_pkg::wave_state_t   state;
  llc_pkg::wave_state_t   next_state;
  logic [31:0]            ctrl;
  logic [5:0]             flags;
  logic [5:0]             next_flags;
  logic [5:0]             clr;
  logic [llc_pkg::DEAD_W-1:0] dead_cnt;
  logic [llc_pkg::CNT_W-1:0]  avg_hi_cnt;
  logic [llc_pkg::CNT_W-1:0]  avg_lo_cnt;
  logic [llc_pkg::CNT_W-1:0]  below_cnt;
  logic [3:0]             cyc_cnt;
  logic [2:0]             peak_run;
  logic [2:0]             burst_cnt;
  logic                   peak_seen;
  logic                   pol_d;
  logic                   cap_flag;
  logic                   bulk_ok;
  logic                   ss_done;
  logic                   below_burst;
  logic                   burst_last;
  logic                   fault_any;
  logic                   run;
  logic                   pol_edge;
  logic                   go;
  logic                   high_side_on;
  logic                   low_side_on;
  logic                   hs_fall;
  logic                   ls_fall;
  logic                   wr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////////////
  // Comparator inputs are asynchronous to the clock

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sync1 <= '0;
      c     <= '0;
    end else begin
      sync1 <= CMP;
      c     <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualifiers

  assign high_side_on = (state == llc_pkg::ST_HIGH);
  assign low_side_on  = (state == llc_pkg::ST_LOW);
  assign hs_fall      = high_side_on && (next_state != llc_pkg::ST_HIGH);
  assign ls_fall      = low_side_on && (next_state != llc_pkg::ST_LOW);
  assign below_burst  = c.feedback_below_burst_level && ss_done;
  assign burst_last   = (burst_cnt == 3'(llc_pkg::BURST_CYCLES));
  assign fault_any    = |flags[4:0];
  assign run          = ctrl[llc_pkg::CTRL_EN_BIT] && bulk_ok && !fault_any
                        && !flags[llc_pkg::ST_RESTART];
  assign pol_edge     = c.current_polarity ^ pol_d;

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ss_done <= 1'b0;
    end else begin
      ss_done <= ctrl[llc_pkg::CTRL_SOFT_START_ENABLED_BIT] && !cap_flag
                 && !c.feedback_below_softstart;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      bulk_ok <= 1'b0;
    end else if (c.bulk_above_start) begin
      bulk_ok <= 1'b1;
    end else if (!c.bulk_above_stop) begin
      bulk_ok <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform state machine

  // Blanking only masks the polarity path; slew done is trusted at once
  assign go = c.slew_done
              || (pol_edge && dead_cnt >= llc_pkg::DEAD_W'(llc_pkg::BLANK_CYC))
              || (dead_cnt >= llc_pkg::DEAD_W'(llc_pkg::DEAD_MAX_CYC - 1));

  always_comb begin
    next_state = state;
    case (state)
      llc_pkg::ST_IDLE: begin
        if (run && !below_burst) next_state = llc_pkg::ST_HIGH;
      end
      llc_pkg::ST_HIGH: begin
        if (!run) next_state = llc_pkg::ST_IDLE;
        else if (burst_last && c.tank_above_cm) next_state = llc_pkg::ST_IDLE;
        else if (c.tank_above_upper) next_state = llc_pkg::ST_DEAD_HL;
      end
      llc_pkg::ST_DEAD_HL: begin
        if (!run) next_state = llc_pkg::ST_IDLE;
        else if (go) next_state = llc_pkg::ST_LOW;
      end
      llc_pkg::ST_LOW: begin
        if (!run) next_state = llc_pkg::ST_IDLE;
        else if (c.tank_below_lower) next_state = llc_pkg::ST_DEAD_LH;
      end
      llc_pkg::ST_DEAD_LH: begin
        if (!run) next_state = llc_pkg::ST_IDLE;
        else if (go) next_state = llc_pkg::ST_HIGH;
      end
      default: next_state = llc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state    <= llc_pkg::ST_IDLE;
      dead_cnt <= '0;
      pol_d    <= 1'b0;
    end else begin
      state <= next_state;
      pol_d <= c.current_polarity;
      if (next_state == llc_pkg::ST_DEAD_HL || next_state == llc_pkg::ST_DEAD_LH) begin
        if (next_state == state) dead_cnt <= dead_cnt + 1'b1;
        else dead_cnt <= '0;
      end else begin
        dead_cnt <= '0;
      end
    end
  end

  // Gates follow the next state so they turn with the state register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      HIGH_GATE_OUT    <= 1'b0;
      LOW_GATE_OUT     <= 1'b0;
      AVG_PATH_SEL     <= 1'b0;
      TANK_CLAMP       <= 1'b1;
      DRIVER_LOW_POWER <= 1'b1;
      WINDING_SAMPLE   <= 1'b0;
      RAMP_ENABLE      <= 1'b0;
      BURST_SEL_GND    <= 1'b1;
      BULK_OV_SEL_RISE <= 1'b1;
    end else begin
      HIGH_GATE_OUT    <= (next_state == llc_pkg::ST_HIGH) && !c.boot_supply_uv;
      LOW_GATE_OUT     <= (next_state == llc_pkg::ST_LOW) && !c.regulated_supply_uv;
      AVG_PATH_SEL     <= (next_state == llc_pkg::ST_HIGH);
      TANK_CLAMP       <= (next_state == llc_pkg::ST_IDLE);
      DRIVER_LOW_POWER <= (next_state == llc_pkg::ST_IDLE);
      WINDING_SAMPLE   <= ls_fall;
      RAMP_ENABLE      <= 1'b1;
      BURST_SEL_GND    <= !ss_done;
      BULK_OV_SEL_RISE <= !c.bulk_overvoltage;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      RAMP_SOURCE <= 1'b1;
    end else if (hs_fall || ls_fall) begin
      RAMP_SOURCE <= !RAMP_SOURCE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capacitive region and burst counting

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      cap_flag <= 1'b0;
    end else if (hs_fall) begin
      cap_flag <= !c.current_polarity;
    end else if (ls_fall) begin
      cap_flag <= c.current_polarity;
    end
  end

  // Counts low-side turn-offs while below, holding at BURST_CYCLES; a partial cycle after the drop is counted
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      burst_cnt <= '0;
    end else if (!below_burst) begin
      burst_cnt <= '0;
    end else if (ls_fall && !burst_last) begin
      burst_cnt <= burst_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault qualification

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      avg_hi_cnt <= '0;
      avg_lo_cnt <= '0;
      below_cnt  <= '0;
    end else begin
      avg_hi_cnt <= c.avg_overcurrent_high ? avg_hi_cnt + 1'b1 : '0;
      avg_lo_cnt <= c.avg_overcurrent_low ? avg_lo_cnt + 1'b1 : '0;
      below_cnt  <= below_burst ? below_cnt + 1'b1 : '0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      peak_seen <= 1'b0;
      peak_run  <= '0;
      cyc_cnt   <= '0;
    end else begin
      if (!ctrl[llc_pkg::CTRL_EN_BIT]) cyc_cnt <= '0;
      else if (hs_fall && cyc_cnt != 4'(llc_pkg::PEAK_IGNORE)) cyc_cnt <= cyc_cnt + 1'b1;
      if (hs_fall) peak_seen <= 1'b0;
      else if (high_side_on && c.peak_overcurrent) peak_seen <= 1'b1;
      // One-shot; a held count would re-raise the flag after every clear
      if (peak_run == 3'(llc_pkg::PEAK_EVENTS)) peak_run <= '0;
      else if (hs_fall && cyc_cnt == 4'(llc_pkg::PEAK_IGNORE)) begin
        peak_run <= (peak_seen || c.peak_overcurrent) ? peak_run + 1'b1 : '0;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    next_flags = flags & ~clr;
    if (peak_run == 3'(llc_pkg::PEAK_EVENTS)) next_flags[llc_pkg::ST_PEAK] = 1'b1;
    if (avg_hi_cnt == llc_pkg::CNT_W'(AVG_HI_CYCLES - 1))
      next_flags[llc_pkg::ST_AVG_HI] = 1'b1;
    if (avg_lo_cnt == llc_pkg::CNT_W'(AVG_LO_CYCLES - 1))
      next_flags[llc_pkg::ST_AVG_LO] = 1'b1;
    if (c.bulk_overvoltage) next_flags[llc_pkg::ST_BULK_OV] = 1'b1;
    if (c.output_ov) next_flags[llc_pkg::ST_OUT_OV] = 1'b1;
    if (below_cnt == llc_pkg::CNT_W'(RESTART_CYCLES - 1))
      next_flags[llc_pkg::ST_RESTART] = 1'b1;
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign FAULT          = fault_any;
  assign RESTART_REQ    = flags[llc_pkg::ST_RESTART];
  assign SS_PULLDOWN    = cap_flag;
  assign SOFTSTART_DONE = ss_done;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  assign wr      = PSEL && PENABLE && PWRITE;
  assign clr     = (wr && hit(PADDR, llc_pkg::STAT_OFF)) ? PWDATA[5:0] : 6'h00;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE
                   && !hit(PADDR, llc_pkg::CTRL_OFF) && !hit(PADDR, llc_pkg::STAT_OFF);

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl <= llc_pkg::CTRL_RESET;
    end else if (wr && hit(PADDR, llc_pkg::CTRL_OFF)) begin
      ctrl <= {30'h0, PWDATA[1:0]};
    end
  end

  // Read data is captured in the setup cycle, ready for the access cycle
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      if (hit(PADDR, llc_pkg::CTRL_OFF)) PRDATA <= ctrl;
      else if (hit(PADDR, llc_pkg::STAT_OFF))
        PRDATA <= {11'h000, state, 5'h00, bulk_ok, ss_done, cap_flag, 2'h0, flags};
      else PRDATA <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_burst_gnd;
    !ss_done |-> !below_burst ##1 BURST_SEL_GND;
  endproperty
  a_burst_gnd: assert property (p_burst_gnd) else $error("burst selector not ground");

  property p_clamp;
    (state == llc_pkg::ST_IDLE) |-> TANK_CLAMP;
  endproperty
  a_clamp: assert property (p_clamp) else $error("tank not clamped in idle");

  property p_slew_wait;
    $rose(LOW_GATE_OUT) |-> $past(state == llc_pkg::ST_DEAD_HL || state == llc_pkg::ST_LOW);
  endproperty
  a_slew_wait: assert property (p_slew_wait) else $error("low gate without dead time");

  property p_blank;
    (state == llc_pkg::ST_DEAD_HL && dead_cnt < llc_pkg::DEAD_W'(llc_pkg::BLANK_CYC)
     && !c.slew_done && run) |=> (state == llc_pkg::ST_DEAD_HL);
  endproperty
  a_blank: assert property (p_blank) else $error("polarity edge not blanked");

  property p_uv_low;
    c.regulated_supply_uv |=> !LOW_GATE_OUT;
  endproperty
  a_uv_low: assert property (p_uv_low) else $error("low gate on in undervoltage");

  property p_fault_off;
    fault_any ##1 fault_any |-> !HIGH_GATE_OUT && !LOW_GATE_OUT;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("gate on during fault");

  property p_peak;
    $rose(flags[llc_pkg::ST_PEAK]) |-> $past(peak_run, 1) == 3'(llc_pkg::PEAK_EVENTS)
                                       || $past(flags[llc_pkg::ST_PEAK], 2);
  endproperty
  a_peak: assert property (p_peak) else $error("peak fault without four cycles");

  property p_avg_hi;
    $rose(flags[llc_pkg::ST_AVG_HI]) |-> $past(avg_hi_cnt) == llc_pkg::CNT_W'(AVG_HI_CYCLES - 1);
  endproperty
  a_avg_hi: assert property (p_avg_hi) else $error("average fault timing wrong");

  property p_cap;
    (hs_fall && !c.current_polarity) || (ls_fall && c.current_polarity)
      |=> cap_flag && SS_PULLDOWN;
  endproperty
  a_cap: assert property (p_cap) else $error("capacitive flag not set");

endmodule

// ---- verif/llc_tank_model.sv ----
`timescale 1ns/1ps
module llc_tank_model (
  input  wire logic       clk,      // System clock
  input  wire logic       hi,       // High gate
  input  wire logic       lo,       // Low gate
  input  wire logic [7:0] slew_dly, // Slew done delay, 0 never
  input  wire logic [7:0] flip_dly, // Polarity flip delay, 0 never
  input  wire logic       cap,      // Capacitive operation
  output logic      [4:0] tank      // Upper, lower, mid, polarity, slew
);
  logic [7:0] on_cnt = 8'h00;
  logic [7:0] dead_cnt = 8'h00;
  logic       last_hi = 1'b0;
  logic       base;

  always_ff @(posedge clk) begin
    if (hi || lo) begin
      on_cnt   <= on_cnt + 8'h01;
      dead_cnt <= 8'h00;
      last_hi  <= hi;
    end else begin
      on_cnt   <= 8'h00;
      dead_cnt <= (dead_cnt == 8'hFF) ? dead_cnt : dead_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing a fixed time into each on-time; polarity wrong way when capacitive
  assign base    = last_hi ^ cap;
  assign tank[4] = hi && on_cnt >= 8'h0A;
  assign tank[3] = lo && on_cnt >= 8'h0A;
  assign tank[2] = last_hi;
  assign tank[1] = (flip_dly != 8'h00 && dead_cnt >= flip_dly) ? ~base : base;
  assign tank[0] = !hi && !lo && slew_dly != 8'h00 && dead_cnt >= slew_dly;
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [10:0] ext = 11'h060;
  logic [7:0]  slew_dly = 8'h03;
  logic [7:0]  flip_dly = 8'h00;
  logic        cap = 1'b0;
  logic [4:0]  tank;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, hi, lo, lowpwr, clamp, ramp_en, ramp_src, src;
  logic        avg_sel, burst_gnd, ov_rise, wsample, ss_pd, ss_done, fault, restart;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          overlap = 0;
  int          n;

  always #10 clk = ~clk;

  llc_waveform_protection_logic #(
    .AVG_HI_CYCLES(20), .AVG_LO_CYCLES(40), .RESTART_CYCLES(400)
  ) dut (
    .CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CMP(llc_pkg::cmp_t'({tank, ext})), .HIGH_GATE_OUT(hi), .LOW_GATE_OUT(lo),
    .DRIVER_LOW_POWER(lowpwr), .TANK_CLAMP(clamp), .RAMP_ENABLE(ramp_en),
    .RAMP_SOURCE(ramp_src), .AVG_PATH_SEL(avg_sel), .BURST_SEL_GND(burst_gnd),
    .BULK_OV_SEL_RISE(ov_rise), .WINDING_SAMPLE(wsample), .SS_PULLDOWN(ss_pd),
    .SOFTSTART_DONE(ss_done), .FAULT(fault), .RESTART_REQ(restart)
  );

  llc_tank_model model (.clk(clk), .hi(hi), .lo(lo), .slew_dly(slew_dly),
    .flip_dly(flip_dly), .cap(cap), .tank(tank));

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (hi === 1'b1 && lo === 1'b1)
      overlap <= overlap + 1;
    if (cycles == 40000) begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic pick(input int w);
    logic [6:0] s;
    s = {wsample, restart, lowpwr, fault, ss_pd, lo, hi};
    return s[w];
  endfunction

  // Bounded wait; n keeps the cycles spent
  task automatic wait_lvl(input int w, input logic v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic falls_until(input int w, input int s, input int lim);
    logic p;
    p = pick(w);
    n = 0;
    repeat (lim) begin
      if (pick(s) === 1'b1)
        break;
      @(posedge clk);
      if (p === 1'b1 && pick(w) === 1'b0)
        n++;
      p = pick(w);
    end
  endtask

  task automatic busy(input int w, input int k);
    n = 0;
    repeat (k) begin
      @(posedge clk);
      if (pick(w) === 1'b1)
        n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({clamp, burst_gnd, lowpwr, ramp_en, ramp_src, hi, lo, fault}, 8'hF8);
    apb(1'b0, llc_pkg::CTRL_OFF, 32'h0);
    chk(rd, llc_pkg::CTRL_RESET);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, llc_pkg::STAT_OFF, 32'h0);
    chk(rd, 32'h0001_0400);
  endtask

  task automatic t_start();
    apb(1'b1, llc_pkg::CTRL_OFF, 32'h0000_0003);
    apb(1'b0, llc_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h0000_0003);
    wait_lvl(0, 1'b1, 100);
    chk({hi, avg_sel, clamp, lowpwr}, 4'hC);
    src = ramp_src;
    wait_lvl(1, 1'b1, 100);
    chk({avg_sel, ramp_src ^ src, ramp_en}, 3'b011);
    wait_lvl(1, 1'b0, 100);
    wait_lvl(6, 1'b1, 4);
    chk(wsample, 1'b1);
  endtask

  task automatic t_dead(input logic [7:0] s, input logic [7:0] f, input int a, input int b);
    slew_dly <= s;
    flip_dly <= f;
    wait_lvl(0, 1'b1, 200);
    wait_lvl(0, 1'b0, 200);
    wait_lvl(1, 1'b1, 200);
    chk(n >= a && n <= b, 1'b1);
  endtask

  task automatic t_cap();
    chk({ss_done, burst_gnd}, 2'b10);
    cap <= 1'b1;
    wait_lvl(2, 1'b1, 100);
    ticks(2);
    chk({ss_pd, ss_done, burst_gnd}, 3'b101);
    cap <= 1'b0;
    wait_lvl(2, 1'b0, 100);
    ticks(2);
    chk({ss_pd, ss_done, burst_gnd}, 3'b010);
    ext[2] <= 1'b1;
    ticks(5);
    chk(ss_done, 1'b0);
    ext[2] <= 1'b0;
    ticks(5);
  endtask

  task automatic t_uv();
    ext[1] <= 1'b1;
    ticks(10);
    busy(0, 300);
    chk(n, 0);
    ext[1] <= 1'b0;
    ext[0] <= 1'b1;
    ticks(10);
    busy(1, 300);
    chk(n, 0);
    ext[0] <= 1'b0;
    ext[6] <= 1'b0;
    busy(0, 200);
    chk(n != 0, 1'b1);
    ext[5] <= 1'b0;
    ticks(10);
    busy(0, 200);
    chk(n, 0);
    ext[6:5] <= 2'b11;
  endtask

  // Short glitch must not trip; held level trips near count c
  task automatic t_fault(input int idx, input int ok, input int c, input int b);
    wait_lvl(0, 1'b1, 200);
    if (ok > 0) begin
      ext[idx] <= 1'b1;
      ticks(ok);
      ext[idx] <= 1'b0;
      ticks(4);
      chk(fault, 1'b0);
    end
    ext[idx] <= 1'b1;
    wait_lvl(3, 1'b1, c + 10);
    chk(n >= c && n <= c + 5, 1'b1);
    ticks(2);
    chk({hi, lo, ov_rise}, {2'b00, idx != 7});
    ext[idx] <= 1'b0;
    apb(1'b0, llc_pkg::STAT_OFF, 32'h0);
    chk(rd[5:0], 6'(1 << b));
    apb(1'b1, llc_pkg::STAT_OFF, 32'h0000_003F);
    apb(1'b0, llc_pkg::STAT_OFF, 32'h0);
    chk(rd[5:0], 6'h00);
  endtask

  task automatic t_peak();
    apb(1'b1, llc_pkg::CTRL_OFF, 32'h0);
    ext[10] <= 1'b1;
    apb(1'b1, llc_pkg::CTRL_OFF, 32'h0000_0003);
    falls_until(0, 3, 3000);
    chk(n, 19);
    ext[10] <= 1'b0;
    apb(1'b1, llc_pkg::STAT_OFF, 32'h0000_003F);
  endtask

  task automatic t_burst();
    wait_lvl(0, 1'b1, 200);
    ext[3] <= 1'b1;
    falls_until(1, 4, 1000);
    chk(n, 4);
    ticks(2);
    chk({lowpwr, clamp, hi, lo}, 4'hC);
    wait_lvl(5, 1'b1, 500);
    chk(restart, 1'b1);
    ext[3] <= 1'b0;
    busy(0, 50);
    chk(n, 0);
    apb(1'b1, llc_pkg::STAT_OFF, 32'h0000_0020);
    wait_lvl(0, 1'b1, 200);
    chk(hi, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ticks(6);
    rst <= 1'b0;
    ticks(2);
    t_reset();
    t_start();
    t_dead(8'h03, 8'h00, 3, 10);
    t_dead(8'h00, 8'h1E, 30, 40);
    t_dead(8'h00, 8'h05, 46, 58);
    t_dead(8'h00, 8'h00, 46, 58);
    t_dead(8'h03, 8'h00, 3, 10);
    t_cap();
    t_uv();
    t_fault(9, 15, 20, 1);
    t_fault(8, 35, 40, 2);
    t_fault(7, 0, 2, 3);
    t_fault(4, 0, 2, 4);
    t_peak();
    t_burst();
    chk(overlap, 0);
    close_out();
  end
endmodule
